// ===== rtl/dccr_pkg.sv
// package: register map, field positions and reset values of the dual comparator control block
// Operation
// - bit 7 of a comparator control register switches that comparator on when set and off when clear.
// - read-only bit 6 shows the comparator result: 1 when plus exceeds minus, swapped when polarity is set.
// - bit 4 inverts the comparator result before it reaches the status bit and the pin path.
// - bit 5 routes the result to the comparator's own output pin; when clear it stays internal.
// - the pin is driven only while output enable is 1, comparator enable is 1 and port direction is 0.
// - bits 1-0 pick one of four shared minus pins, codes 00 to 11 giving pins zero to three.
// - bit 3 is unimplemented, ignores writes and reads as zero.
// - any read of a control register loads the present result into a reference latch; a mismatch edge raises the flag.
// - a write to a control register also clears the mismatch, as every write starts with a read.
// - the internal comparator result is sampled once every clock; the pin path adds one more register stage after it.
// - reset returns both control registers to reset values, turning both comparators off.
package dccr_pkg;
  // byte addresses on the register bus
  localparam logic [4:0] CMP_ONE_CTRL_OFS = 5'h00;
  localparam logic [4:0] CMP_TWO_CTRL_OFS = 5'h04;
  localparam logic [4:0] IRQ_STATUS_OFS   = 5'h08;
  localparam logic [4:0] IRQ_MASK_OFS     = 5'h0C;
  // control register field positions
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_RESULT    = 6;
  localparam int BIT_PIN_DRIVE = 5;
  localparam int BIT_INVERT    = 4;
  localparam int BIT_SPARE     = 3;
  localparam int BIT_REF_SEL   = 2;
  localparam int BIT_CHAN_HI   = 1;
  localparam int BIT_CHAN_LO   = 0;
  // interrupt status and mask positions
  localparam int IRQ_CMP_ONE = 0;
  localparam int IRQ_CMP_TWO = 1;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET  = 2'h0;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// ===== rtl/dccr_sync.sv
// two flip-flop synchroniser for the asynchronous comparator levels
`timescale 1ns/100ps
`default_nettype none
module dccr_sync
  import dccr_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
  } dccr_sync_s;

  dccr_sync_s syncReg;
  dccr_sync_s syncNext;

  // stage one feeds stage two only, never any logic
  always_comb begin
    syncNext          = syncReg;
    syncNext.stageOne = asyncIn;
    syncNext.stageTwo = syncReg.stageOne;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.stageTwo;
endmodule
`default_nettype wire

// ===== rtl/dccr_channel.sv
// one comparator: control register, sampled result, mismatch latch and pin drive
`timescale 1ns/100ps
`default_nettype none
module dccr_channel
  import dccr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rawAbove,
  input  wire logic       portDir,
  input  wire logic       wrStrobe,
  input  wire logic [7:0] wrData,
  input  wire logic       rdCapture,
  output logic      [7:0] ctrlView,
  output logic            mismatch,
  output logic            changeEvent,
  output logic            pinOut,
  output logic            pinOe
);
  typedef struct packed {
    logic       enable;
    logic       pinDrive;
    logic       invert;
    logic       refSel;
    logic [1:0] chan;
    logic       result;
    logic       refLatch;
    logic       misPrev;
    logic       pinOut;
    logic       pinOe;
  } dccr_chan_s;

  dccr_chan_s chanReg;
  dccr_chan_s chanNext;

  // mismatch level and its rising edge
  assign mismatch    = chanReg.refLatch ^ chanReg.result;
  assign changeEvent = mismatch & ~chanReg.misPrev;

  // next state of the comparator channel
  always_comb begin
    chanNext = chanReg;
    // a disabled comparator reports zero so that status never floats
    chanNext.result  = chanReg.enable & (rawAbove ^ chanReg.invert);
    // reads and writes alike reload the latch, so a write clears mismatch
    if (rdCapture) begin
      chanNext.refLatch = chanReg.result;
    end
    chanNext.misPrev = mismatch;
    // pin path: one register stage keeps the top outputs glitch free
    chanNext.pinOut = chanReg.result;
    chanNext.pinOe  = chanReg.enable & chanReg.pinDrive & ~portDir;
    if (wrStrobe) begin
      chanNext.enable   = wrData[BIT_ENABLE];
      chanNext.pinDrive = wrData[BIT_PIN_DRIVE];
      chanNext.invert   = wrData[BIT_INVERT];
      chanNext.refSel   = wrData[BIT_REF_SEL];
      chanNext.chan     = wrData[BIT_CHAN_HI:BIT_CHAN_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chanReg <= '0;
    end else begin
      chanReg <= chanNext;
    end
  end

  // readback view; bit 3 is hard zero
  assign ctrlView = {chanReg.enable, chanReg.result, chanReg.pinDrive, chanReg.invert,
                     1'b0, chanReg.refSel, chanReg.chan};
  assign pinOut   = chanReg.pinOut;
  assign pinOe    = chanReg.pinOe;
endmodule
`default_nettype wire

// ===== rtl/dccr_top.sv
// top of the dual comparator control block: wishbone slave, two channels, interrupt logic
`timescale 1ns/100ps
`default_nettype none
module dccr_top
  import dccr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  // analog comparator results, asynchronous: 1 when plus exceeds minus
  input  wire logic        cmpOneAbove,
  input  wire logic        cmpTwoAbove,
  // port direction bits of the two output pins, 0 means output
  input  wire logic        portDirOne,
  input  wire logic        portDirTwo,
  // analog controls
  output logic             cmpOneEnable,
  output logic             cmpOneRefSelect,
  output logic      [1:0]  cmpOneNegChannel,
  output logic             cmpTwoEnable,
  output logic             cmpTwoRefSelect,
  output logic      [1:0]  cmpTwoNegChannel,
  // comparator output pins
  output logic             cmpOnePinOut,
  output logic             cmpOnePinOe,
  output logic             cmpTwoPinOut,
  output logic             cmpTwoPinOe
);
  typedef struct packed {
    logic        ack;
    logic [31:0] datO;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
  } dccr_bus_s;

  dccr_bus_s busReg;
  dccr_bus_s busNext;

  logic       reqNew;
  logic       commit;
  logic       wrLane;
  logic [1:0] aboveSync;
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic       misOne;
  logic       misTwo;
  logic       evtOne;
  logic       evtTwo;
  logic       wrOne;
  logic       wrTwo;
  logic       capOne;
  logic       capTwo;
  logic [1:0] clrBits;

  // request taken on first cycle, completed on the ack cycle
  assign reqNew = wb_cyc_i & wb_stb_i & ~busReg.ack;
  assign commit = wb_cyc_i & wb_stb_i & busReg.ack;
  assign wrLane = commit & wb_we_i & wb_sel_i[0];

  // writes land on the ack edge, latch capture on the request edge
  assign wrOne  = wrLane & (wb_adr_i == CMP_ONE_CTRL_OFS);
  assign wrTwo  = wrLane & (wb_adr_i == CMP_TWO_CTRL_OFS);
  assign capOne = reqNew & (wb_adr_i == CMP_ONE_CTRL_OFS);
  assign capTwo = reqNew & (wb_adr_i == CMP_TWO_CTRL_OFS);

  // analog levels change at any time, so sample them twice
  dccr_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk              (clk),
    .reset            (reset),
    .asyncIn          ({cmpTwoAbove, cmpOneAbove}),
    .syncOut          (aboveSync)
  );

  dccr_channel u_cmp_one (
    .clk         (clk),
    .reset       (reset),
    .rawAbove    (aboveSync[0]),
    .portDir     (portDirOne),
    .wrStrobe    (wrOne),
    .wrData      (wb_dat_i[7:0]),
    .rdCapture   (capOne),
    .ctrlView    (ctrlOne),
    .mismatch    (misOne),
    .changeEvent (evtOne),
    .pinOut      (cmpOnePinOut),
    .pinOe       (cmpOnePinOe)
  );

  dccr_channel u_cmp_two (
    .clk         (clk),
    .reset       (reset),
    .rawAbove    (aboveSync[1]),
    .portDir     (portDirTwo),
    .wrStrobe    (wrTwo),
    .wrData      (wb_dat_i[7:0]),
    .rdCapture   (capTwo),
    .ctrlView    (ctrlTwo),
    .mismatch    (misTwo),
    .changeEvent (evtTwo),
    .pinOut      (cmpTwoPinOut),
    .pinOe       (cmpTwoPinOe)
  );

  // write-one-to-clear of the sticky status bits
  assign clrBits = (wrLane && wb_adr_i == IRQ_STATUS_OFS) ? wb_dat_i[1:0] : 2'h0;

  // bus answer, status, mask and interrupt
  always_comb begin
    busNext      = busReg;
    busNext.ack  = reqNew;
    busNext.datO = 32'h0000_0000;
    if (reqNew && !wb_we_i) begin
      case (wb_adr_i)
        CMP_ONE_CTRL_OFS: busNext.datO = {24'h00_0000, ctrlOne};
        CMP_TWO_CTRL_OFS: busNext.datO = {24'h00_0000, ctrlTwo};
        IRQ_STATUS_OFS:   busNext.datO = {30'h0000_0000, busReg.status};
        IRQ_MASK_OFS:     busNext.datO = {30'h0000_0000, busReg.mask};
        default:          busNext.datO = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    // a new event wins over a clear in the same cycle
    busNext.status = (busReg.status & ~clrBits) | {evtTwo, evtOne};
    if (wrLane && wb_adr_i == IRQ_MASK_OFS) begin
      busNext.mask = wb_dat_i[1:0];
    end
    busNext.irq = |(busNext.status & busNext.mask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busReg        <= '0;
      busReg.status <= IRQ_RESET;
      busReg.mask   <= IRQ_RESET;
    end else begin
      busReg <= busNext;
    end
  end

  // every output below is a flip-flop in this module or a channel
  assign wb_ack_o         = busReg.ack;
  assign wb_dat_o         = busReg.datO;
  assign irq              = busReg.irq;
  assign cmpOneEnable     = ctrlOne[BIT_ENABLE];
  assign cmpOneRefSelect  = ctrlOne[BIT_REF_SEL];
  assign cmpOneNegChannel = ctrlOne[BIT_CHAN_HI:BIT_CHAN_LO];
  assign cmpTwoEnable     = ctrlTwo[BIT_ENABLE];
  assign cmpTwoRefSelect  = ctrlTwo[BIT_REF_SEL];
  assign cmpTwoNegChannel = ctrlTwo[BIT_CHAN_HI:BIT_CHAN_LO];

  // checks, all on clk with synchronous reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_enable_write;
    wrOne |=> (cmpOneEnable == $past(wb_dat_i[7]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow write");

  property p_result_plain;
    $past(ctrlOne[BIT_INVERT] == 1'b0) && !$past(wrOne) |->
      ctrlOne[BIT_RESULT] == ($past(ctrlOne[BIT_ENABLE]) & $past(aboveSync[0]));
  endproperty
  a_result_plain: assert property (p_result_plain)
    else $error("result bit wrong with polarity clear");

  property p_result_inverted;
    $past(ctrlTwo[BIT_INVERT]) && $past(ctrlTwo[BIT_ENABLE]) |->
      ctrlTwo[BIT_RESULT] == !$past(aboveSync[1]);
  endproperty
  a_result_inverted: assert property (p_result_inverted)
    else $error("result bit not inverted with polarity set");

  property p_pin_internal;
    !ctrlOne[BIT_PIN_DRIVE] |=> !cmpOnePinOe;
  endproperty
  a_pin_internal: assert property (p_pin_internal)
    else $error("pin driven while output enable clear");

  property p_pin_three_terms;
    ##1 cmpTwoPinOe == $past(ctrlTwo[BIT_ENABLE] & ctrlTwo[BIT_PIN_DRIVE] & ~portDirTwo);
  endproperty
  a_pin_three_terms: assert property (p_pin_three_terms)
    else $error("pin enable not the and of three terms");

  property p_channel_write;
    wrTwo |=> cmpTwoNegChannel == $past(wb_dat_i[1:0]) &&
              cmpTwoRefSelect == $past(wb_dat_i[2]);
  endproperty
  a_channel_write: assert property (p_channel_write)
    else $error("channel or reference select not written");

  // the unimplemented bit must never reach the bus, whatever was written
  property p_spare_zero;
    wb_ack_o |-> !wb_dat_o[BIT_SPARE];
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("unimplemented bit on read data");

  // read data is zero outside the ack cycle
  property p_idle_data;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("read data not zero outside ack");

  // an edge of comparator one sets its status bit on the next edge
  property p_event_one;
    evtOne |=> busReg.status[IRQ_CMP_ONE];
  endproperty
  a_event_one: assert property (p_event_one)
    else $error("mismatch edge of comparator one did not set status");
  property p_spare_read;
    ##1 !ctrlOne[BIT_SPARE] && !ctrlTwo[BIT_SPARE];
  endproperty
  a_spare_read: assert property (p_spare_read)
    else $error("unimplemented bit reads one");

  property p_capture_clears;
    capOne ##1 !capOne |-> !misOne || (ctrlOne[BIT_RESULT] != $past(ctrlOne[BIT_RESULT]));
  endproperty
  a_capture_clears: assert property (p_capture_clears)
    else $error("read did not reload mismatch latch");

  property p_event_sticky;
    evtTwo |=> busReg.status[IRQ_CMP_TWO] [*2];
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("mismatch edge did not set status");

  property p_irq_level;
    ##1 irq == |(busReg.status & busReg.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not tied to masked status");

  property p_reset_values;
    @(posedge clk) disable iff (1'b0) reset |=> ctrlOne == CTRL_RESET && ctrlTwo == CTRL_RESET &&
                             !cmpOnePinOe && !cmpTwoPinOe;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("control registers not cleared by reset");

  property p_ack_one_cycle;
    reqNew |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("ack not a single cycle after request");

  // main scenarios
  c_pin_drive: cover property (wrOne ##[1:4] cmpOnePinOe);
  c_event_irq: cover property (evtOne ##1 irq);
  c_clear_race: cover property (evtTwo && clrBits[IRQ_CMP_TWO]);
  c_spare_written: cover property (wrOne && wb_dat_i[BIT_SPARE]);
endmodule
`default_nettype wire

// ===== verification/dccr_testbench.sv
// self-checking testbench of the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import dccr_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [4:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        irq;
  logic [1:0]  above;
  logic [1:0]  portDir;
  logic [1:0]  en;
  logic [1:0]  refSel;
  logic [1:0]  pinOut;
  logic [1:0]  pinOe;
  logic [1:0]  chanOne;
  logic [1:0]  chanTwo;
  logic [31:0] rdat;
  logic [4:0]  ofs;
  logic [7:0]  d;
  int          errCount;
  int          samplesChecked;

  dccr_top DUT (
    .clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .irq(irq), .cmpOneAbove(above[0]), .cmpTwoAbove(above[1]),
    .portDirOne(portDir[0]), .portDirTwo(portDir[1]), .cmpOneEnable(en[0]),
    .cmpOneRefSelect(refSel[0]), .cmpOneNegChannel(chanOne), .cmpTwoEnable(en[1]),
    .cmpTwoRefSelect(refSel[1]), .cmpTwoNegChannel(chanTwo), .cmpOnePinOut(pinOut[0]),
    .cmpOnePinOe(pinOe[0]), .cmpTwoPinOut(pinOut[1]), .cmpTwoPinOe(pinOe[1])
  );

  // free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    if (errCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; the wait is bounded so a silent slave shows up as a mismatch
  task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    check("ack", {31'h0, wbAck}, 32'h00000001);
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
    wb_cycle(1'b1, adr, wd);
  endtask

  task automatic rd(input logic [4:0] adr, input logic [7:0] exp, input string what);
    wb_cycle(1'b0, adr, 8'h00);
    check(what, rdat, {24'h000000, exp});
  endtask

  // let the updates of the last edge land before looking at outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_above(input int c, input logic v);
    @(posedge clk);
    above[c] <= v;
  endtask

  // a hang ends the run through the same verdict
  initial begin
    #500000;
    errCount++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 5'h00;
    wbSel = 4'hF;
    wbDatW = 32'h00000000;
    above = 2'h0;
    portDir = 2'h0;
    errCount = 0;
    samplesChecked = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    check("enables after reset", {30'h0, en}, 32'h0);
    check("pin oe after reset", {30'h0, pinOe}, 32'h0);
    rd(CMP_ONE_CTRL_OFS, 8'h00, "ctrl one reset");
    rd(CMP_TWO_CTRL_OFS, 8'h00, "ctrl two reset");
    rd(IRQ_STATUS_OFS, 8'h00, "status reset");
    rd(IRQ_MASK_OFS, 8'h00, "mask reset");
    // change events: edge sets the flag, reads and writes rearm the mismatch latch
    wr(CMP_ONE_CTRL_OFS, 8'h80);
    wr(IRQ_MASK_OFS, 8'h03);
    set_above(0, 1'b1);
    settle(6);
    check("irq on change", {31'h0, irq}, 32'h1);
    rd(IRQ_STATUS_OFS, 8'h01, "status on change");
    wr(IRQ_STATUS_OFS, 8'h01);
    rd(IRQ_STATUS_OFS, 8'h00, "status with level only");
    rd(CMP_ONE_CTRL_OFS, 8'hC0, "ctrl one result high");
    set_above(0, 1'b0);
    settle(6);
    rd(IRQ_STATUS_OFS, 8'h01, "status after return");
    wr(IRQ_STATUS_OFS, 8'h01);
    wr(CMP_ONE_CTRL_OFS, 8'h80);
    set_above(0, 1'b1);
    settle(6);
    rd(IRQ_STATUS_OFS, 8'h01, "status after write rearm");
    wr(IRQ_MASK_OFS, 8'h02);
    settle(2);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(IRQ_STATUS_OFS, 8'h03);
    rd(IRQ_STATUS_OFS, 8'h00, "status cleared");
    // every channel code, both invert and reference values, spare bit written as one
    set_above(0, 1'b0);
    for (int c = 0; c < 2; c++) begin
      ofs = (c == 1) ? CMP_TWO_CTRL_OFS : CMP_ONE_CTRL_OFS;
      for (int k = 0; k < 4; k++) begin
        d = 8'h88 | (k[0] ? 8'h10 : 8'h00) | (k[1] ? 8'h04 : 8'h00) | 8'(k[1:0]);
        wr(ofs, d);
        settle(4);
        check("enable out", {31'h0, en[c]}, 32'h1);
        check("ref select out", {31'h0, refSel[c]}, {31'h0, k[1]});
        check("channel out", {30'h0, (c == 1) ? chanTwo : chanOne}, 32'(k[1:0]));
        rd(ofs, (d & 8'hF7) | (k[0] ? 8'h40 : 8'h00), "ctrl readback");
      end
    end
    // pin drive over all enable, output enable and direction combinations
    set_above(0, 1'b1);
    set_above(1, 1'b1);
    for (int c = 0; c < 2; c++) begin
      ofs = (c == 1) ? CMP_TWO_CTRL_OFS : CMP_ONE_CTRL_OFS;
      for (int m = 0; m < 8; m++) begin
        @(posedge clk);
        portDir[c] <= m[0];
        wr(ofs, {m[2], 1'b0, m[1], 5'h00});
        settle(4);
        check("pin oe", {31'h0, pinOe[c]}, {31'h0, m[2] & m[1] & ~m[0]});
        check("pin value", {31'h0, pinOut[c]}, {31'h0, m[2]});
        check("enable out", {31'h0, en[c]}, {31'h0, m[2]});
      end
    end
    // unmapped places are acked and read as zero
    wr(5'h10, 8'hFF);
    rd(5'h10, 8'h00, "unmapped read");
    // reset in mid-run turns both comparators off again
    wr(CMP_TWO_CTRL_OFS, 8'hFF);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    check("enables after second reset", {30'h0, en}, 32'h0);
    check("pin oe after second reset", {30'h0, pinOe}, 32'h0);
    check("irq after second reset", {31'h0, irq}, 32'h0);
    rd(CMP_TWO_CTRL_OFS, 8'h00, "ctrl two second reset");
    give_verdict();
  end
endmodule
`default_nettype wire
